// ==== hdl/link_phy_pkg.sv ====
package link_phy_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] OFS_PRIMARY_TIMEOUT = 12'h854;
  localparam logic [11:0] OFS_PERIODIC_RETRAIN = 12'h864;
  localparam logic [11:0] OFS_EPARAM_SELECT    = 12'h8a0;
  localparam logic [11:0] OFS_EPARAM_MISC      = 12'h8b4;

  // ==========================================================
  // Field positions
  localparam int BITLOCK_EXP_LSB   = 16;
  localparam int INBAND_EXP_LSB    = 8;
  localparam int PTV_RSVD_LSB      = 0;
  localparam int DUR_UNIT_BIT      = 22;
  localparam int PKT_CNT_LSB       = 14;
  localparam int INTERVAL_EXP_LSB  = 10;
  localparam int INTERVAL_BASE_LSB = 0;
  localparam int SELECTOR_LSB      = 16;
  localparam int MISC_BITS_LSB     = 21;
  localparam int EQ_OFF_BIT        = 20;
  localparam int PRE1_LSB          = 16;
  localparam int POST2_SIGN_BIT    = 12;
  localparam int POST2_LSB         = 8;
  localparam int POST1_LSB         = 0;

  // ==========================================================
  // Values after reset, and the transmit EQ parameter selector code
  localparam logic [3:0] BITLOCK_EXP_RESET = 4'h1;
  localparam logic [3:0] INBAND_EXP_RESET  = 4'h1;
  localparam logic [3:0] PTV_RSVD_RESET    = 4'h2;
  localparam logic [3:0] PRE1_RESET        = 4'h2;
  localparam logic [4:0] POST1_RESET       = 5'h10;
  localparam logic [7:0] TX_EQ_PARAM_CODE  = 8'h05;

  // ==========================================================
  // Unit interval counts
  localparam int UI_PER_TSL          = 64;
  localparam int TSL_PER_TIMEOUT     = 128;
  localparam int TSL_PER_INTERVAL    = 16;
  localparam int UI_PER_INTERVAL     = UI_PER_TSL * TSL_PER_INTERVAL;
  localparam int TIMEOUT_SHIFT       = $clog2(UI_PER_TSL * TSL_PER_TIMEOUT);
  localparam int INTERVAL_SHIFT      = $clog2(UI_PER_INTERVAL);
  localparam logic [6:0] DUR_UNIT_COARSE = 7'h40;
  localparam logic [6:0] DUR_UNIT_FINE   = 7'h10;

  // ==========================================================
  // State tracker codes
  localparam logic [4:0] CODE_RETRAINING = 5'h0e;
  localparam logic [4:0] CODE_OPERATING  = 5'h0f;

endpackage : link_phy_pkg

// ==== hdl/eparam_store.sv ====
`timescale 1ns/1ns
// ==========================================================
// Per-parameter storage for the misc control bits
module eparam_store #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 256
) (
  input  wire logic                     clk_sys,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic                     write_en,
  input  wire logic [WIDTH-1:0]         write_data,
  output logic      [WIDTH-1:0]         read_data
);
  initial
  begin
    if (WIDTH < 1 || DEPTH < 2)
      $error("eparam_store: bad geometry");
  end

  logic [WIDTH-1:0] cells [DEPTH];

  // No reset on the array; read data is a registered copy
  always_ff @(posedge clk_sys)
  begin
    if (write_en)
      cells[addr] <= write_data;
    read_data <= cells[addr];
  end
endmodule : eparam_store

// ==== hdl/exp_timeout.sv ====
`timescale 1ns/1ns
// ==========================================================
// Exponential timeout counted in unit intervals
module exp_timeout #(
  parameter int CNT_W = 29
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic       ui_tick,
  input  wire logic [3:0] exponent,
  output logic            expired
);
  initial
  begin
    if (CNT_W < 16 + link_phy_pkg::TIMEOUT_SHIFT)
      $error("exp_timeout: counter too narrow");
  end

  logic [CNT_W-1:0] ticks;
  logic             running;
  logic [CNT_W-1:0] target;

  // 2^exponent x 128 training lengths, in UI
  assign target = CNT_W'(1) << (exponent + 5'(link_phy_pkg::TIMEOUT_SHIFT));

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ticks   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (start)
    begin
      ticks   <= '0;
      running <= 1'b1;
      expired <= 1'b0;
    end
    else if (running && ui_tick)
    begin
      if (ticks + CNT_W'(1) == target)
      begin
        running <= 1'b0;
        expired <= 1'b1;
      end
      ticks <= ticks + CNT_W'(1);
    end
  end

  property p_expire_at_target;
    @(posedge clk_sys) disable iff (reset)
      $rose(expired) |-> ticks == target;
  endproperty
  a_expire_at_target: assert property (p_expire_at_target)
    else $error("timeout expired at wrong count");

  property p_start_clears;
    @(posedge clk_sys) disable iff (reset)
      start |=> !expired && ticks == '0;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("timeout not restarted on entry");
endmodule : exp_timeout

// ==== hdl/link_phy_timeout_retrain_eq.sv ====
`timescale 1ns/1ns
// ==========================================================
// Timeout, periodic retraining and equalization control
module link_phy_timeout_retrain_eq #(
  parameter int SEL_DEPTH = 256,
  parameter int MISC_W    = 11
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        cfg_write,
  input  wire logic        cfg_read,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_byte_en,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic        ui_tick,
  input  wire logic        bitlock_enter,
  input  wire logic        inband_reset_enter,
  input  wire logic        link_in_l0,
  input  wire logic [4:0]  train_state_code,
  output logic             bitlock_timeout_expired,
  output logic             inband_init_timeout_expired,
  output logic             retraining_active_state,
  output logic      [4:0]  link_state_code,
  output logic             tx_equalizer_off,
  output logic      [3:0]  precursor1_coeff,
  output logic             postcursor2_sign,
  output logic      [3:0]  postcursor2_coeff,
  output logic      [4:0]  postcursor1_coeff,
  output logic      [MISC_W-1:0] electrical_param_misc_bits
);
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (reset);
  initial
  begin
    if (SEL_DEPTH != 256 || MISC_W != 11)
      $error("link_phy_timeout_retrain_eq: selector is 8 bits, misc field 11 bits");
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction : merge_bytes
  function automatic logic wr_hit(input logic [11:0] ofs);
    return cfg_write && cfg_addr == ofs;
  endfunction : wr_hit
  // ==========================================================
  // Register storage
  logic [3:0] bitlock_timeout_exponent;
  logic [3:0] inband_reset_init_timeout_exponent;
  logic [3:0] ptv_spare;
  logic       retrain_duration_unit_sel;
  logic [7:0] retrain_packet_count;
  logic [3:0] retrain_interval_exponent;
  logic [7:0] retrain_interval_base;
  logic [7:0] electrical_param_selector;
  logic [31:0] image_ptv;
  logic [31:0] image_prt;
  logic [31:0] image_sel;
  logic [31:0] image_misc;
  logic [31:0] new_ptv;
  logic [31:0] new_prt;
  logic [31:0] new_sel;
  logic [31:0] new_misc;
  assign image_ptv = {12'h000, bitlock_timeout_exponent, 4'h0,
                      inband_reset_init_timeout_exponent, 4'h0, ptv_spare};
  assign image_prt = {9'h000, retrain_duration_unit_sel, retrain_packet_count,
                      retrain_interval_exponent, 2'b00, retrain_interval_base};
  assign image_sel = {8'h00, electrical_param_selector, 16'h0000};
  assign image_misc = {electrical_param_misc_bits, tx_equalizer_off, precursor1_coeff,
                       3'b000, postcursor2_sign, postcursor2_coeff, 3'b000,
                       postcursor1_coeff};
  assign new_ptv  = merge_bytes(image_ptv, cfg_wdata, cfg_byte_en);
  assign new_prt  = merge_bytes(image_prt, cfg_wdata, cfg_byte_en);
  assign new_sel  = merge_bytes(image_sel, cfg_wdata, cfg_byte_en);
  assign new_misc = merge_bytes(image_misc, cfg_wdata, cfg_byte_en);
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      bitlock_timeout_exponent           <= link_phy_pkg::BITLOCK_EXP_RESET;
      inband_reset_init_timeout_exponent <= link_phy_pkg::INBAND_EXP_RESET;
      ptv_spare                          <= link_phy_pkg::PTV_RSVD_RESET;
    end
    else if (wr_hit(link_phy_pkg::OFS_PRIMARY_TIMEOUT))
    begin
      bitlock_timeout_exponent <= new_ptv[link_phy_pkg::BITLOCK_EXP_LSB +: 4];
      inband_reset_init_timeout_exponent <= new_ptv[link_phy_pkg::INBAND_EXP_LSB +: 4];
      ptv_spare <= new_ptv[link_phy_pkg::PTV_RSVD_LSB +: 4];
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      retrain_duration_unit_sel <= 1'b0;
      retrain_packet_count      <= 8'h00;
      retrain_interval_exponent <= 4'h0;
      retrain_interval_base     <= 8'h00;
    end
    else if (wr_hit(link_phy_pkg::OFS_PERIODIC_RETRAIN))
    begin
      retrain_duration_unit_sel <= new_prt[link_phy_pkg::DUR_UNIT_BIT];
      retrain_packet_count      <= new_prt[link_phy_pkg::PKT_CNT_LSB +: 8];
      retrain_interval_exponent <= new_prt[link_phy_pkg::INTERVAL_EXP_LSB +: 4];
      retrain_interval_base     <= new_prt[link_phy_pkg::INTERVAL_BASE_LSB +: 8];
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      electrical_param_selector <= 8'h00;
    else if (wr_hit(link_phy_pkg::OFS_EPARAM_SELECT))
      electrical_param_selector <= new_sel[link_phy_pkg::SELECTOR_LSB +: 8];
  end
  // Equalizer controls belong to the transmit EQ parameter only
  logic misc_write;
  logic eq_write;
  // Open-coded: a continuous assign would miss the signals read inside a function
  assign misc_write = cfg_write && cfg_addr == link_phy_pkg::OFS_EPARAM_MISC;
  assign eq_write = misc_write &&
                    electrical_param_selector == link_phy_pkg::TX_EQ_PARAM_CODE;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_equalizer_off  <= 1'b0;
      precursor1_coeff  <= link_phy_pkg::PRE1_RESET;
      postcursor2_sign  <= 1'b0;
      postcursor2_coeff <= 4'h0;
      postcursor1_coeff <= link_phy_pkg::POST1_RESET;
    end
    else if (eq_write)
    begin
      tx_equalizer_off  <= new_misc[link_phy_pkg::EQ_OFF_BIT];
      precursor1_coeff  <= new_misc[link_phy_pkg::PRE1_LSB +: 4];
      postcursor2_sign  <= new_misc[link_phy_pkg::POST2_SIGN_BIT];
      postcursor2_coeff <= new_misc[link_phy_pkg::POST2_LSB +: 4];
      postcursor1_coeff <= new_misc[link_phy_pkg::POST1_LSB +: 5];
    end
  end
  // Misc field only changes when its top byte lane is written
  eparam_store #(
    .WIDTH (MISC_W),
    .DEPTH (SEL_DEPTH)
  ) u_store (
    .clk_sys    (clk_sys),
    .addr       (electrical_param_selector),
    .write_en   (misc_write && cfg_byte_en[3]),
    .write_data (cfg_wdata[link_phy_pkg::MISC_BITS_LSB +: MISC_W]),
    .read_data  (electrical_param_misc_bits)
  );
  // ==========================================================
  // Read path: two cycles so store data reflects a fresh selector
  logic        read_pend;
  logic [11:0] read_addr;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      read_pend  <= 1'b0;
      read_addr  <= 12'h000;
      cfg_rvalid <= 1'b0;
      cfg_rdata  <= 32'h0000_0000;
    end
    else
    begin
      read_pend  <= cfg_read;
      read_addr  <= cfg_addr;
      cfg_rvalid <= read_pend;
      if (read_pend)
      begin
        unique case (read_addr)
          link_phy_pkg::OFS_PRIMARY_TIMEOUT:  cfg_rdata <= image_ptv;
          link_phy_pkg::OFS_PERIODIC_RETRAIN: cfg_rdata <= image_prt;
          link_phy_pkg::OFS_EPARAM_SELECT:    cfg_rdata <= image_sel;
          link_phy_pkg::OFS_EPARAM_MISC:      cfg_rdata <= image_misc;
          default:                            cfg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ==========================================================
  // Training timeouts
  exp_timeout #(.CNT_W (29)) u_bitlock_timer (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .start    (bitlock_enter),
    .ui_tick  (ui_tick),
    .exponent (bitlock_timeout_exponent),
    .expired  (bitlock_timeout_expired)
  );
  exp_timeout #(.CNT_W (29)) u_inband_timer (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .start    (inband_reset_enter),
    .ui_tick  (ui_tick),
    .exponent (inband_reset_init_timeout_exponent),
    .expired  (inband_init_timeout_expired)
  );
  // ==========================================================
  // Periodic retraining scheduler
  typedef enum {WAIT_INTERVAL, RETRAINING} retrain_state_t;
  retrain_state_t retrain_state;
  logic [33:0] ui_count;
  logic [33:0] interval_ui;
  logic [14:0] duration_ui;
  logic [6:0]  dur_unit;
  logic [7:0]  packets;
  // Interval kept in whole UI so counting is exact at any exponent
  assign interval_ui = 34'(retrain_interval_base) <<
                       (5'(link_phy_pkg::INTERVAL_SHIFT) + 5'(retrain_interval_exponent));
  assign dur_unit = retrain_duration_unit_sel ? link_phy_pkg::DUR_UNIT_FINE
                                              : link_phy_pkg::DUR_UNIT_COARSE;
  // A zero packet count still gives one unit so the episode ends
  assign packets = (retrain_packet_count == 8'h00) ? 8'h01 : retrain_packet_count;
  assign duration_ui = 15'(packets * dur_unit);
  always_ff @(posedge clk_sys)
  begin
    if (reset || !link_in_l0)
    begin
      retrain_state <= WAIT_INTERVAL;
      ui_count      <= '0;
    end
    else
    begin
      unique case (retrain_state)
        WAIT_INTERVAL:
        begin
          if (retrain_interval_base == 8'h00)
            ui_count <= '0;
          else if (ui_tick)
          begin
            if (ui_count + 34'd1 >= interval_ui)
            begin
              retrain_state <= RETRAINING;
              ui_count      <= '0;
            end
            else
              ui_count <= ui_count + 34'd1;
          end
        end
        RETRAINING:
        begin
          if (ui_tick)
          begin
            if (ui_count + 34'd1 >= 34'(duration_ui))
            begin
              retrain_state <= WAIT_INTERVAL;
              ui_count      <= '0;
            end
            else
              ui_count <= ui_count + 34'd1;
          end
        end
      endcase
    end
  end
  logic next_retraining;
  assign next_retraining = !reset && link_in_l0 && retrain_state == RETRAINING;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      retraining_active_state <= 1'b0;
      link_state_code         <= 5'h00;
    end
    else
    begin
      retraining_active_state <= next_retraining;
      if (!link_in_l0)
        link_state_code <= train_state_code;
      else if (retrain_state == RETRAINING)
        link_state_code <= link_phy_pkg::CODE_RETRAINING;
      else
        link_state_code <= link_phy_pkg::CODE_OPERATING;
    end
  end
  // ==========================================================
  // Checks
  property p_code_in_retrain;
    retraining_active_state |-> link_state_code == link_phy_pkg::CODE_RETRAINING;
  endproperty
  a_code_in_retrain: assert property (p_code_in_retrain)
    else $error("retraining without retraining code");
  // The reset edge loads zero into the code, so that edge is left out
  property p_code_in_l0;
    $past(link_in_l0) && !$past(reset) && !retraining_active_state |->
      link_state_code == link_phy_pkg::CODE_OPERATING;
  endproperty
  a_code_in_l0: assert property (p_code_in_l0)
    else $error("operating code missing in L0");
  property p_zero_disables;
    retrain_interval_base == 8'h00 && retrain_state == WAIT_INTERVAL |=>
      retrain_state == WAIT_INTERVAL;
  endproperty
  a_zero_disables: assert property (p_zero_disables)
    else $error("retraining started with zero interval");
  sequence s_enter_retrain;
    retrain_state == WAIT_INTERVAL ##1 retrain_state == RETRAINING;
  endsequence
  property p_interval_exact;
    s_enter_retrain |-> $past(ui_count, 1) + 34'd1 >= $past(interval_ui, 1);
  endproperty
  a_interval_exact: assert property (p_interval_exact)
    else $error("retrain started before interval elapsed");
  property p_count_single_ui;
    retrain_state == WAIT_INTERVAL && ui_tick && ui_count + 34'd1 < interval_ui
      && link_in_l0 && retrain_interval_base != 8'h00 |=> ui_count == $past(ui_count) + 34'd1;
  endproperty
  a_count_single_ui: assert property (p_count_single_ui)
    else $error("interval counter skipped a unit interval");
  property p_duration_unit;
    duration_ui == 15'(packets) * (retrain_duration_unit_sel ? 15'd16 : 15'd64);
  endproperty
  a_duration_unit: assert property (p_duration_unit)
    else $error("retrain duration unit wrong");
  property p_sel_write;
    wr_hit(link_phy_pkg::OFS_EPARAM_SELECT) && cfg_byte_en[2] |=>
      electrical_param_selector == $past(cfg_wdata[23:16]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selector not stored");
  property p_eq_only_tx;
    misc_write && electrical_param_selector != link_phy_pkg::TX_EQ_PARAM_CODE |=>
      $stable(tx_equalizer_off) && $stable(postcursor1_coeff);
  endproperty
  a_eq_only_tx: assert property (p_eq_only_tx)
    else $error("EQ controls changed for another parameter");
  property p_read_latency;
    cfg_read |-> ##2 cfg_rvalid;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer late");
endmodule : link_phy_timeout_retrain_eq

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_top;
  // ==========================================================
  // Signals
  logic        clk_sys, reset, cfg_write, cfg_read, cfg_rvalid, ui_tick;
  logic        bitlock_enter, inband_reset_enter, link_in_l0;
  logic        bitlock_timeout_expired, inband_init_timeout_expired;
  logic        retraining_active_state, tx_equalizer_off, postcursor2_sign;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_byte_en, precursor1_coeff, postcursor2_coeff;
  logic [31:0] cfg_wdata, cfg_rdata, exp_v, r, r2;
  logic [4:0]  train_state_code, link_state_code, postcursor1_coeff;
  logic [10:0] electrical_param_misc_bits;
  logic [14:0] eq_out;
  logic [31:0] exp_q[$];
  logic [31:0] prt[2] = '{32'h0040_8001, 32'h0000_4401};
  int          n_fail, total_checks, hits;

  assign eq_out = {tx_equalizer_off, precursor1_coeff, postcursor2_sign, postcursor2_coeff,
                   postcursor1_coeff};

  link_phy_timeout_retrain_eq link_phy_timeout_retrain_eq_i (
    .clk_sys(clk_sys), .reset(reset), .cfg_write(cfg_write), .cfg_read(cfg_read),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .ui_tick(ui_tick),
    .bitlock_enter(bitlock_enter), .inband_reset_enter(inband_reset_enter),
    .link_in_l0(link_in_l0), .train_state_code(train_state_code),
    .bitlock_timeout_expired(bitlock_timeout_expired),
    .inband_init_timeout_expired(inband_init_timeout_expired),
    .retraining_active_state(retraining_active_state), .link_state_code(link_state_code),
    .tx_equalizer_off(tx_equalizer_off), .precursor1_coeff(precursor1_coeff),
    .postcursor2_sign(postcursor2_sign), .postcursor2_coeff(postcursor2_coeff),
    .postcursor1_coeff(postcursor1_coeff),
    .electrical_param_misc_bits(electrical_param_misc_bits)
  );

  // ==========================================================
  // Bus tasks and read answer monitor
  function automatic logic [14:0] eqf(input logic [31:0] v);
    return {v[20:16], v[12:8], v[4:0]};
  endfunction : eqf

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  // Strobe dropped then one idle cycle, so no signal is driven twice in a step
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_byte_en = be;
    cfg_write = 1'b1;
    cyc(1);
    cfg_write = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    cfg_addr = a;
    cfg_read = 1'b1;
    exp_q.push_back(ex);
    cyc(1);
    cfg_read = 1'b0;
    cyc(1);
  endtask : rd

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  always @(negedge clk_sys)
  begin
    if (cfg_rvalid === 1'b1)
    begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_0000;
      `CHK("cfg_rdata", exp_v, cfg_rdata)
    end
  end

  // ==========================================================
  // Clock and main sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    reset = 1'b1;
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_addr = 12'h000;
    cfg_byte_en = 4'hf;
    cfg_wdata = 32'h0;
    ui_tick = 1'b0;
    bitlock_enter = 1'b0;
    inband_reset_enter = 1'b0;
    link_in_l0 = 1'b0;
    void'($urandom(93));
    train_state_code = 5'($urandom);
    cyc(6);
    reset = 1'b0;
    `CHK("eq reset", 15'h0810, eq_out)
    rd(12'h854, 32'h0001_0102);
    rd(12'h864, 32'h0);
    rd(12'h8a0, 32'h0);
    rd(12'h900, 32'h0);
    wr(12'h858, 32'hffff_ffff, 4'hf);
    wr(12'h854, 32'h0000_0000, 4'h4);
    rd(12'h854, 32'h0000_0102);
    $display("test registers done");
    // Bit-lock exponent 0, in-band exponent 1, one tick per cycle
    bitlock_enter = 1'b1;
    inband_reset_enter = 1'b1;
    cyc(1);
    bitlock_enter = 1'b0;
    inband_reset_enter = 1'b0;
    ui_tick = 1'b1;
    cyc(8191);
    `CHK("bitlock early", 1'b0, bitlock_timeout_expired)
    cyc(2);
    `CHK("bitlock", 1'b1, bitlock_timeout_expired)
    cyc(8190);
    `CHK("inband early", 1'b0, inband_init_timeout_expired)
    cyc(2);
    `CHK("inband", 1'b1, inband_init_timeout_expired)
    bitlock_enter = 1'b1;
    cyc(1);
    bitlock_enter = 1'b0;
    cyc(1);
    `CHK("bitlock restart", 1'b0, bitlock_timeout_expired)
    ui_tick = 1'b0;
    $display("test timeouts done");
    r = $urandom;
    r2 = $urandom;
    wr(12'h8a0, 32'h0005_0000, 4'hf);
    rd(12'h8a0, 32'h0005_0000);
    wr(12'h8b4, r, 4'hf);
    `CHK("eq", eqf(r), eq_out)
    `CHK("misc", r[31:21], electrical_param_misc_bits)
    rd(12'h8b4, r & 32'hffff_1f1f);
    wr(12'h8a0, 32'h0007_0000, 4'hf);
    wr(12'h8b4, r2, 4'hf);
    `CHK("eq held", eqf(r), eq_out)
    `CHK("misc other", r2[31:21], electrical_param_misc_bits)
    rd(12'h8b4, (r2 & 32'hffe0_0000) | (r & 32'h001f_1f1f));
    wr(12'h8a0, 32'h0005_0000, 4'hf);
    cyc(1);
    `CHK("misc back", r[31:21], electrical_param_misc_bits)
    $display("test equalization done");
    // Fine unit with two packets, then coarse unit with doubled interval
    for (int e = 0; e < 2; e++)
    begin
      link_in_l0 = 1'b0;
      wr(12'h864, prt[e], 4'hf);
      rd(12'h864, prt[e]);
      link_in_l0 = 1'b1;
      cyc(2);
      `CHK("code l0", 5'h0f, link_state_code)
      ui_tick = 1'b1;
      cyc((1024 << e) - 1);
      `CHK("retrain early", 1'b0, retraining_active_state)
      cyc(4);
      `CHK("retrain", 1'b1, retraining_active_state)
      `CHK("code retrain", 5'h0e, link_state_code)
      cyc(e ? 60 : 28);
      `CHK("episode late", 1'b1, retraining_active_state)
      cyc(6);
      `CHK("episode over", 1'b0, retraining_active_state)
      `CHK("code back", 5'h0f, link_state_code)
      ui_tick = 1'b0;
    end
    wr(12'h864, 32'h0000_0c00, 4'hf);
    ui_tick = 1'b1;
    hits = 0;
    repeat (1200)
    begin
      cyc(1);
      if (retraining_active_state !== 1'b0)
        hits++;
    end
    `CHK("no retrain", 0, hits)
    link_in_l0 = 1'b0;
    cyc(2);
    `CHK("code passthru", train_state_code, link_state_code)
    $display("test retraining done");
    for (int i = 0; i < 20 && exp_q.size() > 0; i++)
      cyc(1);
    `CHK("reads answered", 0, exp_q.size())
    wrap_up();
  end
endmodule : tb_top
